// File: core/sqm_pkg.sv
// Constants, register map and state type of the switch queue and buffer manager.
// Behaviour
// [R1] Queue reset fills the free pool with every pointer and empties all other queues.
// [R2] After reset, each enabled port with link up is granted a free receive pointer.
// [R3] Link loss or disable returns that port's receive and queued pointers to the pool.
// [R4] An enabled port whose link returns is granted a receive pointer again.
// [R5] Queue reset comes from the reset pin, the soft reset bit or a table-size change.
// [R6] A disabled port gets no receive pointer; its share stays in the free pool.
// [R7] Transceiver ports take link from the transceiver; interface ports are up when enabled.
// [R8] The receiving MAC fills memory at its pointer, then hands it back for a new one.
// [R9] An empty pool grants nothing; a frame started without a pointer is dropped.
// [R10] Destinations come from lookup and policy results, then adjusted for flow control and congestion.
// [R11] Flow control is chosen per ingress port; both kinds run side by side.
// [R12] Flow-controlled frames are queued unchanged; pause goes to ports feeding congested queues.
// [R13] Without flow control a frame may be dropped, wholly or for some destinations.
// [R14] Drop decisions look at target queue congestion and at the free pointer count.
// [R15] Each output queue sends in enqueue order; queues drain independently.
// [R16] After a frame is sent its pointer goes to the multicast handler before the next.
// [R17] Single-destination pointers free at once; multi-destination ones after every port sent.
// [R18] A slow or congested port never holds back frames bound for other ports; here flow-controlled sources feeding it can empty the pool and starve them.
// [R19] Packet buffers are a synchronous 8K by 64-bit RAM.
// [R20] A disabled port neither receives, transmits nor learns.
// [R21] Each buffer counts outstanding destinations and frees when the count reaches zero.
// [R22] On reclaim, queued frames count as completed on that port; sole-destination ones are freed.
package sqm_pkg;
	localparam int NPORTS = 6;
	localparam int NBUF = 64;
	localparam int MEM_WORDS = 8192;
	localparam int MEM_DW = 64;
	localparam int MEM_AW = 13;
	localparam int RAM_CLK_MHZ = 50;
	localparam int CLK_MHZ = 40;
	localparam int Q_THRESH = 16;
	localparam int FREE_LOW = 8;
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORT_STATE = 8'h04;
	localparam logic [7:0] OFS_FC_EN = 8'h08;
	localparam logic [7:0] OFS_MII = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_DROP_CNT = 8'h14;
	localparam int CTRL_SOFT_RST_POS = 0;
	localparam int CTRL_TBL_SIZE_POS = 1;
	localparam int STATUS_RUN_POS = 15;
	localparam int STATUS_FC_POS = 16;
	localparam logic [1:0] PS_DISABLED = 2'h0;
	localparam logic [1:0] PS_BLOCKING = 2'h1;
	localparam logic [1:0] PS_LEARNING = 2'h2;
	localparam logic [1:0] PS_FORWARD = 2'h3;
	localparam logic [1:0] TBL_SIZE_RST = 2'h1;
	localparam logic [11:0] PORT_STATE_RST = 12'hfff;
	localparam logic [5:0] FC_EN_RST = 6'h00;
	localparam logic [5:0] MII_RST = 6'h30;
	typedef enum logic [1:0] {
		SQM_INIT = 2'b01,
		SQM_RUN = 2'b10
	} sqm_state_t;
endpackage : sqm_pkg

// File: core/sqm_buffer_manager.sv
// Queue manager, output queues, multicast handler and packet RAM of the switch core.
`timescale 1ns/100ps
module sqm_buffer_manager #(
	parameter int NPORTS = sqm_pkg::NPORTS,
	parameter int NBUF = sqm_pkg::NBUF,
	parameter int Q_THRESH = sqm_pkg::Q_THRESH,
	parameter int FREE_LOW = sqm_pkg::FREE_LOW,
	parameter int MEM_WORDS = sqm_pkg::MEM_WORDS,
	parameter int MEM_DW = sqm_pkg::MEM_DW,
	parameter int MEM_AW = sqm_pkg::MEM_AW
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [sqm_pkg::REG_AW-1:0] reg_addr,
	input wire logic [sqm_pkg::REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sqm_pkg::REG_DW-1:0] reg_rdata,
	input wire logic [NPORTS-1:0] phy_link_up,
	output logic [NPORTS-1:0] rx_ptr_valid,
	output logic [NPORTS*$clog2(NBUF)-1:0] rx_ptr,
	input wire logic [NPORTS-1:0] rx_start,
	input wire logic [NPORTS-1:0] rx_done_req,
	output logic [NPORTS-1:0] rx_done_ack,
	input wire logic [NPORTS*NPORTS-1:0] lookup_dest,
	input wire logic [NPORTS*NPORTS-1:0] policy_mask,
	output logic [NPORTS-1:0] tx_valid,
	output logic [NPORTS*$clog2(NBUF)-1:0] tx_ptr,
	input wire logic [NPORTS-1:0] tx_done_req,
	output logic [NPORTS-1:0] tx_done_ack,
	output logic [NPORTS-1:0] fc_assert,
	output logic [NPORTS-1:0] learn_en,
	output logic qm_ready,
	input wire logic mem_wr_en,
	input wire logic [MEM_AW-1:0] mem_wr_addr,
	input wire logic [MEM_DW-1:0] mem_wr_data,
	input wire logic mem_rd_en,
	input wire logic [MEM_AW-1:0] mem_rd_addr,
	output logic [MEM_DW-1:0] mem_rd_data
);
	localparam int PW = $clog2(NBUF);
	localparam int CW = PW + 1;
	localparam int RW = $clog2(NPORTS + 1);
	localparam int SW = $clog2(NPORTS);

	function automatic logic [PW-1:0] lowest_idx(input logic [NBUF-1:0] v);
		logic [PW-1:0] r;
		r = '0;
		for (int k = NBUF - 1; k >= 0; k--)
		begin
			if (v[k])
				r = PW'(k);
		end
		return r;
	endfunction : lowest_idx

	function automatic logic [CW-1:0] pop_count(input logic [NBUF-1:0] v);
		logic [CW-1:0] c;
		c = '0;
		for (int k = 0; k < NBUF; k++)
			c = c + CW'(v[k]);
		return c;
	endfunction : pop_count

	sqm_pkg::sqm_state_t state_ff;
	logic [2*NPORTS-1:0] port_state_ff;
	logic [NPORTS-1:0] fc_en_ff;
	logic [NPORTS-1:0] mii_ff;
	logic [1:0] tbl_size_ff;
	logic [15:0] drop_cnt_ff;
	logic [sqm_pkg::REG_DW-1:0] reg_rdata_ff;
	logic [NBUF-1:0] free_ff;
	logic [NPORTS-1:0] rx_vld_ff;
	logic [NPORTS-1:0][PW-1:0] rx_ptr_ff;
	logic [NBUF-1:0][RW-1:0] refcnt_ff;
	logic [MEM_DW-1:0] ram_ff [MEM_WORDS];
	logic [MEM_DW-1:0] mem_rd_data_ff;

	logic qm_clr;
	logic init;
	logic run;
	logic [NPORTS-1:0] active;
	logic [NPORTS-1:0] cong;
	logic [NPORTS-1:0][CW-1:0] q_cnt;
	logic [NPORTS-1:0][PW-1:0] q_head;
	logic [NPORTS-1:0][NPORTS-1:0] src_map;
	logic [CW-1:0] free_cnt;
	logic [NPORTS-1:0] enq_req;
	logic enq_hit;
	logic [SW-1:0] enq_port;
	logic [PW-1:0] enq_ptr;
	logic enq_fc;
	logic [NPORTS-1:0] enq_raw;
	logic [NPORTS-1:0] enq_dest;
	logic [NPORTS-1:0] enq_sel;
	logic [NPORTS-1:0] ret_req;
	logic ret_hit;
	logic [SW-1:0] ret_port;
	logic [PW-1:0] ret_ptr;
	logic ret_last;
	logic [NPORTS-1:0] alloc_req;
	logic alloc_hit;
	logic [SW-1:0] alloc_port;
	logic [PW-1:0] alloc_ptr;
	logic [15:0] nxt_drop_cnt;

	// Hardware pin acts through rst_n; soft reset and table-size change clear the queues.
	assign qm_clr = reg_wr && reg_addr == sqm_pkg::OFS_CTRL &&
		(reg_wdata[sqm_pkg::CTRL_SOFT_RST_POS] ||
		reg_wdata[sqm_pkg::CTRL_TBL_SIZE_POS +: 2] != tbl_size_ff); // [R5]
	assign init = state_ff == sqm_pkg::SQM_INIT || qm_clr;
	assign run = !init;
	assign qm_ready = state_ff == sqm_pkg::SQM_RUN;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state_ff <= sqm_pkg::SQM_INIT;
		else if (qm_clr)
			state_ff <= sqm_pkg::SQM_INIT; // [R5]
		else
			state_ff <= sqm_pkg::SQM_RUN;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port_state_ff <= (2*NPORTS)'(sqm_pkg::PORT_STATE_RST);
			fc_en_ff <= NPORTS'(sqm_pkg::FC_EN_RST);
			mii_ff <= NPORTS'(sqm_pkg::MII_RST);
			tbl_size_ff <= sqm_pkg::TBL_SIZE_RST;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				sqm_pkg::OFS_CTRL: tbl_size_ff <= reg_wdata[sqm_pkg::CTRL_TBL_SIZE_POS +: 2];
				sqm_pkg::OFS_PORT_STATE: port_state_ff <= reg_wdata[2*NPORTS-1:0];
				sqm_pkg::OFS_FC_EN: fc_en_ff <= reg_wdata[NPORTS-1:0]; // [R11]
				sqm_pkg::OFS_MII: mii_ff <= reg_wdata[NPORTS-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_ff <= '0;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				sqm_pkg::OFS_CTRL: reg_rdata_ff <= 32'(tbl_size_ff) << sqm_pkg::CTRL_TBL_SIZE_POS;
				sqm_pkg::OFS_PORT_STATE: reg_rdata_ff <= 32'(port_state_ff);
				sqm_pkg::OFS_FC_EN: reg_rdata_ff <= 32'(fc_en_ff);
				sqm_pkg::OFS_MII: reg_rdata_ff <= 32'(mii_ff);
				sqm_pkg::OFS_STATUS: reg_rdata_ff <= 32'(free_cnt) |
					(32'(qm_ready) << sqm_pkg::STATUS_RUN_POS) |
					(32'(fc_assert) << sqm_pkg::STATUS_FC_POS);
				sqm_pkg::OFS_DROP_CNT: reg_rdata_ff <= 32'(drop_cnt_ff);
				default: reg_rdata_ff <= '0;
			endcase
		end
		else
			reg_rdata_ff <= '0;
	end
	assign reg_rdata = reg_rdata_ff;

	// Port qualification, congestion and flow-control pause, one slice per port.
	for (genvar p = 0; p < NPORTS; p++)
	begin : g_port
		logic [1:0] ps;
		assign ps = port_state_ff[2*p +: 2];
		assign active[p] = ps != sqm_pkg::PS_DISABLED && (mii_ff[p] || phy_link_up[p]); // [R6] [R7]
		assign learn_en[p] = active[p] && (ps == sqm_pkg::PS_LEARNING ||
			ps == sqm_pkg::PS_FORWARD); // [R20]
		assign cong[p] = q_cnt[p] >= CW'(Q_THRESH) || free_cnt < CW'(FREE_LOW); // [R14]
		always_comb
		begin
			fc_assert[p] = 1'b0;
			for (int q = 0; q < NPORTS; q++)
				fc_assert[p] = fc_assert[p] | (src_map[q][p] & cong[q]); // [R12]
			fc_assert[p] = fc_assert[p] & fc_en_ff[p] & run;
		end
		assign rx_ptr_valid[p] = rx_vld_ff[p];
		assign rx_ptr[p*PW +: PW] = rx_ptr_ff[p];
		// A queue of a dead or disabled port shows nothing; the flush drains it.
		assign tx_valid[p] = run && active[p] && q_cnt[p] != '0; // [R20]
		assign tx_ptr[p*PW +: PW] = q_head[p];
		assign enq_sel[p] = enq_hit && enq_port == SW'(p);
		assign rx_done_ack[p] = enq_sel[p]; // [R8]
		assign tx_done_ack[p] = ret_hit && ret_port == SW'(p) && active[p]; // [R16]
	end

	assign free_cnt = pop_count(free_ff);

	// One completed reception is switched per cycle, lowest port first.
	assign enq_req = rx_done_req & active & rx_vld_ff & {NPORTS{run}};
	assign enq_hit = |enq_req;
	assign enq_port = SW'(lowest_idx(NBUF'(enq_req)));
	assign enq_ptr = rx_ptr_ff[enq_port];
	assign enq_fc = fc_en_ff[enq_port];
	assign enq_raw = lookup_dest[enq_port*NPORTS +: NPORTS] &
		policy_mask[enq_port*NPORTS +: NPORTS] & active; // [R10] [R20]
	// Flow-controlled sources keep every destination; others lose congested ones only.
	assign enq_dest = enq_fc ? enq_raw : (enq_raw & ~cong); // [R12] [R13] [R14] [R18]

	// One transmitted or flushed frame is retired per cycle by the multicast handler.
	for (genvar p = 0; p < NPORTS; p++)
	begin : g_ret
		assign ret_req[p] = run && q_cnt[p] != '0 && (active[p] ? tx_done_req[p] : 1'b1); // [R3] [R22]
	end
	assign ret_hit = |ret_req;
	assign ret_port = SW'(lowest_idx(NBUF'(ret_req)));
	assign ret_ptr = q_head[ret_port];
	assign ret_last = refcnt_ff[ret_ptr] == RW'(1); // [R17] [R21]

	// Receive pointers go to waiting ports while the pool holds any.
	assign alloc_req = {NPORTS{run}} & active & ~rx_vld_ff & ~enq_sel; // [R2] [R4] [R6]
	assign alloc_hit = |alloc_req && |free_ff; // [R9]
	assign alloc_port = SW'(lowest_idx(NBUF'(alloc_req)));
	assign alloc_ptr = lowest_idx(free_ff);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_vld_ff <= '0;
			rx_ptr_ff <= '0;
		end
		else
		begin
			for (int p = 0; p < NPORTS; p++)
			begin
				if (init || !active[p] || enq_sel[p])
					rx_vld_ff[p] <= 1'b0; // [R1] [R3] [R8]
				else if (alloc_hit && alloc_port == SW'(p))
				begin
					rx_vld_ff[p] <= 1'b1; // [R2] [R4]
					rx_ptr_ff[p] <= alloc_ptr;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			free_ff <= '1;
		else if (init)
			free_ff <= '1; // [R1]
		else
		begin
			for (int p = 0; p < NPORTS; p++)
			begin
				if (rx_vld_ff[p] && !active[p])
					free_ff[rx_ptr_ff[p]] <= 1'b1; // [R3]
			end
			if (enq_hit && enq_dest == '0)
				free_ff[enq_ptr] <= 1'b1; // [R13]
			if (ret_hit && ret_last)
				free_ff[ret_ptr] <= 1'b1; // [R17] [R21]
			if (alloc_hit)
				free_ff[alloc_ptr] <= 1'b0; // [R2]
		end
	end

	// The enqueued buffer is in no queue yet, so it never meets the retiring one.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			refcnt_ff <= '0;
		else
		begin
			if (enq_hit)
				refcnt_ff[enq_ptr] <= RW'(pop_count(NBUF'(enq_dest))); // [R21]
			if (ret_hit)
				refcnt_ff[ret_ptr] <= refcnt_ff[ret_ptr] - RW'(1); // [R21] [R22]
		end
	end

	always_comb
	begin
		nxt_drop_cnt = drop_cnt_ff + 16'(pop_count(NBUF'(rx_start & ~rx_vld_ff & active))); // [R9]
		if (enq_hit && enq_dest == '0 && enq_raw != '0)
			nxt_drop_cnt = nxt_drop_cnt + 16'h0001; // [R13]
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			drop_cnt_ff <= '0;
		else if (run)
			drop_cnt_ff <= nxt_drop_cnt;
	end

	// Output queues: one FIFO per port, deep enough for every buffer, so pushes never stall.
	for (genvar q = 0; q < NPORTS; q++)
	begin : g_queue
		logic [PW-1:0] slot_ff [NBUF];
		logic [PW-1:0] head_ff;
		logic [PW-1:0] tail_ff;
		logic [CW-1:0] cnt_ff;
		logic [NPORTS-1:0] src_ff;
		logic push;
		logic pop;
		assign push = enq_hit && enq_dest[q];
		assign pop = ret_hit && ret_port == SW'(q);
		assign q_cnt[q] = cnt_ff;
		assign q_head[q] = slot_ff[head_ff];
		assign src_map[q] = src_ff;

		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
				slot_ff <= '{default: '0};
			else if (push)
				slot_ff[tail_ff] <= enq_ptr; // [R15]
		end

		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
			begin
				head_ff <= '0;
				tail_ff <= '0;
				cnt_ff <= '0;
			end
			else if (init)
			begin
				head_ff <= '0; // [R1]
				tail_ff <= '0;
				cnt_ff <= '0;
			end
			else
			begin
				if (push)
					tail_ff <= tail_ff + PW'(1); // [R15]
				if (pop)
					head_ff <= head_ff + PW'(1); // [R15] [R16]
				cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
			end
		end

		// Sources that fed this queue while congested are paused until it recovers.
		always_ff @(posedge clock or negedge rst_n)
		begin
			if (!rst_n)
				src_ff <= '0;
			else if (init || !cong[q])
				src_ff <= '0; // [R12]
			else if (push && enq_fc)
				src_ff[enq_port] <= 1'b1; // [R12]
		end
	end

	// Packet RAM; the MACs address it as pointer times buffer size plus offset.
	always_ff @(posedge clock)
	begin
		if (mem_wr_en)
			ram_ff[mem_wr_addr] <= mem_wr_data; // [R19] [R8]
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			mem_rd_data_ff <= '0;
		else if (mem_rd_en)
			mem_rd_data_ff <= ram_ff[mem_rd_addr]; // [R19]
	end
	assign mem_rd_data = mem_rd_data_ff;
endmodule : sqm_buffer_manager

// File: testbench/sqm_chk.sv
// Port-level assertions for the queue manager.
`timescale 1ns/100ps
module sqm_chk #(
	parameter int NPORTS = 6
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic [sqm_pkg::REG_DW-1:0] reg_rdata,
	input wire logic [NPORTS-1:0] rx_ptr_valid,
	input wire logic [NPORTS-1:0] rx_done_req,
	input wire logic [NPORTS-1:0] rx_done_ack,
	input wire logic [NPORTS-1:0] tx_valid,
	input wire logic [NPORTS-1:0] tx_done_req,
	input wire logic [NPORTS-1:0] tx_done_ack,
	input wire logic [NPORTS-1:0] fc_assert,
	input wire logic qm_ready
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// A queue reset is one cycle of init, so running must come back almost at once.
	sequence s_back_up;
		##[1:3] qm_ready;
	endsequence
	a_rx_ack_cause: assert property ((rx_done_ack & ~(rx_done_req & rx_ptr_valid)) == '0)
		else $error("receive ack without pointer and request");
	a_rx_ack_single: assert property ($onehot0(rx_done_ack))
		else $error("two receive acks in one cycle");
	a_rx_ptr_taken: assert property (|rx_done_ack |=> (rx_ptr_valid & $past(rx_done_ack)) == '0)
		else $error("pointer kept after frame handed over");
	a_tx_ack_cause: assert property ((tx_done_ack & tx_valid & ~tx_done_req) == '0)
		else $error("head retired before the mac finished");
	a_tx_ack_single: assert property ($onehot0(tx_done_ack))
		else $error("two retires in one cycle");
	a_idle_in_init: assert property (!qm_ready |-> (tx_valid | rx_done_ack) == '0)
		else $error("traffic while the manager is not running");
	a_reset_brief: assert property ($fell(qm_ready) |-> s_back_up)
		else $error("queue reset did not return to running");
	a_fc_needs_run: assert property (|fc_assert |-> qm_ready)
		else $error("pause while the manager is not running");
	a_rdata_window: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its cycle");
endmodule : sqm_chk

bind sqm_buffer_manager sqm_chk #(.NPORTS(NPORTS)) sqm_chk_i (.clock(clock), .rst_n(rst_n),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ptr_valid(rx_ptr_valid),
	.rx_done_req(rx_done_req), .rx_done_ack(rx_done_ack), .tx_valid(tx_valid),
	.tx_done_req(tx_done_req), .tx_done_ack(tx_done_ack), .fc_assert(fc_assert),
	.qm_ready(qm_ready));

// File: testbench/sqm_mac_model.sv
// Behavioural port MACs on the far side of the queue manager.
`timescale 1ns/100ps
module sqm_mac_model #(
	parameter int NPORTS = 6
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [NPORTS-1:0] rx_go,
	input wire logic [NPORTS-1:0] tx_stall,
	input wire logic [NPORTS-1:0] rx_ptr_valid,
	input wire logic [NPORTS-1:0] rx_done_ack,
	input wire logic [NPORTS-1:0] tx_valid,
	input wire logic [NPORTS-1:0] tx_done_ack,
	output logic [NPORTS-1:0] rx_done_req,
	output logic [NPORTS-1:0] tx_done_req
);
	// A frame is reported only while a pointer is held, and held until taken.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rx_done_req <= '0;
		else
			rx_done_req <= (rx_done_req | (rx_go & rx_ptr_valid)) & ~rx_done_ack;
	end
	// A stalled port is the slow answer; a flushed queue withdraws the report.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			tx_done_req <= '0;
		else
			tx_done_req <= (tx_done_req | ~tx_stall) & tx_valid & ~tx_done_ack;
	end
endmodule : sqm_mac_model

// File: testbench/testbench.sv
// Self-checking bench for the queue manager.
`timescale 1ns/100ps
module testbench;
	localparam int NP = sqm_pkg::NPORTS;
	logic clock, rst_n, reg_wr, reg_rd, qm_ready, mem_wr_en, mem_rd_en;
	logic [sqm_pkg::REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, f0;
	logic [NP-1:0] phy_link_up, rx_ptr_valid, rx_start, rx_done_req, rx_done_ack, tx_valid;
	logic [NP-1:0] tx_done_req, tx_done_ack, fc_assert, learn_en, rx_go, tx_stall;
	logic [NP*6-1:0] rx_ptr, tx_ptr;
	logic [NP*NP-1:0] lookup_dest, policy_mask;
	logic [12:0] mem_wr_addr, mem_rd_addr;
	logic [63:0] mem_wr_data, mem_rd_data, md;
	logic [5:0] ptr;
	logic [5:0] expq[$];
	logic [5:0] gotq[$];
	int errors, num_checks, seed, i, falls, f1, r3, r4;
	int ret[NP];
	logic [31:0] rexp[9] = '{32'h2, 32'hfff, 32'h0, 32'h30, 32'h803a, 32'h0, 32'h0, 32'h0, 32'h0};

	sqm_buffer_manager sqm_buffer_manager_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.phy_link_up(phy_link_up), .rx_ptr_valid(rx_ptr_valid), .rx_ptr(rx_ptr),
		.rx_start(rx_start), .rx_done_req(rx_done_req), .rx_done_ack(rx_done_ack),
		.lookup_dest(lookup_dest), .policy_mask(policy_mask), .tx_valid(tx_valid),
		.tx_ptr(tx_ptr), .tx_done_req(tx_done_req), .tx_done_ack(tx_done_ack),
		.fc_assert(fc_assert), .learn_en(learn_en), .qm_ready(qm_ready),
		.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
	sqm_mac_model sqm_mac_model_i (.clock(clock), .rst_n(rst_n), .rx_go(rx_go),
		.tx_stall(tx_stall), .rx_ptr_valid(rx_ptr_valid), .rx_done_ack(rx_done_ack),
		.tx_valid(tx_valid), .tx_done_ack(tx_done_ack), .rx_done_req(rx_done_req),
		.tx_done_req(tx_done_req));

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		for (int p = 0; p < NP; p++)
			if (tx_done_ack[p] === 1'b1)
				ret[p]++;
		if (tx_done_ack[3] === 1'b1)
			gotq.push_back(tx_ptr[18+:6]);
		if ($fell(qm_ready))
			falls++;
	end

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd

	task automatic await(input bit txq, input logic [NP-1:0] want);
		logic [NP-1:0] seen;
		for (int c = 0; c < 400; c++)
		begin
			@(posedge clock);
			#1 seen = txq ? tx_valid : rx_ptr_valid;
			if (seen === want)
				return;
		end
		chk("wait", want, seen);
		conclude();
	endtask : await

	task automatic send(input int s, input logic [NP-1:0] d);
		@(posedge clock);
		lookup_dest[s*NP+:NP] <= d;
		rx_go[s] <= 1'b1;
		for (int c = 0; c < 400; c++)
		begin
			@(posedge clock);
			if (rx_done_ack[s] === 1'b1)
			begin
				ptr = rx_ptr[s*6+:6];
				rx_go[s] <= 1'b0;
				return;
			end
		end
		chk("ack", 1, 0);
		conclude();
	endtask : send

	initial
	begin
		seed = 79;
		rst_n = 1'b0;
		{reg_wr, reg_rd, mem_wr_en, mem_rd_en, reg_addr, reg_wdata} = '0;
		{mem_wr_addr, mem_rd_addr, mem_wr_data, rx_start, rx_go, tx_stall, lookup_dest} = '0;
		{phy_link_up, policy_mask} = '1;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		await(1'b0, 6'h3f);
		wr(sqm_pkg::OFS_STATUS, '1);
		wr(8'h20, '1);
		for (i = 0; i < 9; i++)
		begin
			rd(8'(i * 4));
			chk("reg", rexp[i], rv);
		end
		@(posedge clock);
		phy_link_up <= 6'h1e;
		await(1'b0, 6'h3e);
		rd(sqm_pkg::OFS_STATUS);
		chk("free", 32'h803b, rv);
		@(posedge clock);
		phy_link_up <= 6'h3f;
		await(1'b0, 6'h3f);
		wr(sqm_pkg::OFS_PORT_STATE, 32'hf87);
		await(1'b0, 6'h3b);
		chk("learn", 6'h39, learn_en);
		wr(sqm_pkg::OFS_PORT_STATE, 32'hfff);
		await(1'b0, 6'h3f);
		md = {$random(seed), $random(seed)};
		@(posedge clock);
		{mem_wr_en, mem_wr_addr, mem_wr_data} <= {1'b1, rx_ptr[6+:6], 7'h05, md};
		@(posedge clock);
		{mem_wr_en, mem_rd_en, mem_rd_addr} <= {1'b0, 1'b1, rx_ptr[6+:6], 7'h05};
		@(posedge clock);
		mem_rd_en <= 1'b0;
		#1 chk("ram", md, mem_rd_data);
		@(posedge clock);
		tx_stall <= 6'h08;
		policy_mask[6+:6] <= 6'h2f;
		f1 = ret[4];
		for (i = 0; i < 4; i++)
		begin
			send(1, 6'h18 | (6'($random(seed)) & 6'h21));
			expq.push_back(ptr);
		end
		tx_stall <= '0;
		policy_mask <= '1;
		await(1'b1, '0);
		chk("count", expq.size(), gotq.size());
		foreach (expq[k]) chk("order", expq[k], gotq[k]);
		chk("masked", f1, ret[4]);
		@(posedge clock);
		tx_stall <= 6'h18;
		send(0, 6'h18);
		rd(sqm_pkg::OFS_STATUS);
		f0 = rv;
		@(posedge clock);
		tx_stall <= 6'h10;
		await(1'b1, 6'h10);
		rd(sqm_pkg::OFS_STATUS);
		chk("mcast", f0, rv);
		@(posedge clock);
		tx_stall <= '0;
		await(1'b1, '0);
		rd(sqm_pkg::OFS_STATUS);
		chk("mcast", f0 + 1, rv);
		@(posedge clock);
		tx_stall <= 6'h08;
		send(1, 6'h08);
		send(1, 6'h08);
		phy_link_up <= 6'h37;
		await(1'b0, 6'h37);
		await(1'b1, '0);
		rd(sqm_pkg::OFS_STATUS);
		chk("flush", 32'h803b, rv);
		@(posedge clock);
		{phy_link_up, tx_stall} <= {6'h3f, 6'h08};
		await(1'b0, 6'h3f);
		wr(sqm_pkg::OFS_FC_EN, 32'h1);
		rd(sqm_pkg::OFS_DROP_CNT);
		{f0, r3, r4} = {rv, ret[3], ret[4]};
		for (i = 0; i < 18; i++)
			send(1, 6'h18);
		send(1, 6'h08);
		rd(sqm_pkg::OFS_DROP_CNT);
		chk("drop", f0 + 1, rv);
		chk("pause", 6'h0, fc_assert);
		chk("fast", r4 + 18, ret[4]);
		for (i = 0; i < 70 && rx_ptr_valid[0] === 1'b1; i++)
		begin
			send(0, 6'h08);
			repeat (4) @(posedge clock);
		end
		chk("pause", 6'h01, fc_assert);
		rd(sqm_pkg::OFS_STATUS);
		chk("empty", 32'h18000, rv);
		@(posedge clock);
		rx_start <= 6'h01;
		@(posedge clock);
		rx_start <= '0;
		rd(sqm_pkg::OFS_DROP_CNT);
		chk("drop", f0 + 2, rv);
		@(posedge clock);
		tx_stall <= '0;
		await(1'b1, '0);
		chk("lossless", r3 + 16 + i, ret[3]);
		await(1'b0, 6'h3f);
		chk("pause", 6'h0, fc_assert);
		rd(sqm_pkg::OFS_STATUS);
		chk("free", 32'h803a, rv);
		wr(sqm_pkg::OFS_FC_EN, 32'h0);
		f1 = falls;
		wr(sqm_pkg::OFS_CTRL, 32'h3);
		await(1'b0, 6'h3f);
		wr(sqm_pkg::OFS_CTRL, 32'h4);
		await(1'b0, 6'h3f);
		wr(sqm_pkg::OFS_CTRL, 32'h4);
		rd(sqm_pkg::OFS_CTRL);
		chk("ctrl", 32'h4, rv);
		chk("resets", 2, falls - f1);
		conclude();
	end
endmodule : testbench
